// >>> rtl/art_pkg.sv
// Constants, register map and field layout of the auto-reload timer two
// ---------------------------------------------------------------------------
// Overview of operation
// - Sixteen-bit counter from two addressable bytes
// - Split bit clear: one sixteen-bit reload counter
// - Sixteen-bit wrap loads both reload bytes
// - Sixteen-bit wrap sets high overflow flag
// - Timer interrupt on each sixteen-bit overflow
// - Low enable adds interrupt on low wrap
// - Sixteen-bit clock: core, core/12, external/8
// - External divide-by-8 synchronised to core clock
// - Split: two bytes, each reloads itself
// - Split: run gates high byte only
// - Byte select one: core clock, else shared
// - Separate clock selects for high, low
// - Split: each byte wrap sets own flag
// - Split: interrupts per high, optionally low
// - Flags cleared only by software writes
// - Capture copies count to reload, sets flag
// ---------------------------------------------------------------------------
package art_pkg;

	// -----------------------------------------------------------------------
	// Register byte addresses
	// -----------------------------------------------------------------------
	localparam logic [7:0] ART_OFF_CTRL   = 8'h00; // timer_two_control
	localparam logic [7:0] ART_OFF_CNT_LO = 8'h04; // count_low_byte
	localparam logic [7:0] ART_OFF_CNT_HI = 8'h08; // count_high_byte
	localparam logic [7:0] ART_OFF_RLD_LO = 8'h0c; // reload_low_byte
	localparam logic [7:0] ART_OFF_RLD_HI = 8'h10; // reload_high_byte
	localparam logic [7:0] ART_OFF_CKSEL  = 8'h14; // clock_select_register
	localparam logic [7:0] ART_OFF_IEN    = 8'h18; // interrupt_enable_register

	// -----------------------------------------------------------------------
	// Field positions
	// -----------------------------------------------------------------------
	localparam int ART_B_HFLAG   = 7; // high_overflow_flag
	localparam int ART_B_LFLAG   = 6; // low_overflow_flag
	localparam int ART_B_LIEN    = 5; // low_overflow_irq_enable
	localparam int ART_B_CAPEN   = 4; // capture enable
	localparam int ART_B_SPLIT   = 3; // split_mode_select
	localparam int ART_B_RUN     = 2; // run_control
	localparam int ART_B_CAPSRC  = 1; // capture source: 1 external
	localparam int ART_B_XCLK    = 0; // external_clock_select
	localparam int ART_B_HCKSEL  = 5; // high_byte_clock_select
	localparam int ART_B_LCKSEL  = 4; // low_byte_clock_select
	localparam int ART_B_TIMIEN  = 5; // timer interrupt enable

	// -----------------------------------------------------------------------
	// Reset values, limits and dividers
	// -----------------------------------------------------------------------
	localparam logic [7:0] ART_RST_BYTE = 8'h00;
	localparam logic [7:0] ART_BYTE_MAX = 8'hff;
	localparam logic [7:0] ART_BYTE_ONE = 8'h01;
	localparam logic [3:0] ART_DIV12_LAST = 4'hb; // core clock / 12
	localparam logic [2:0] ART_DIV8_LAST  = 3'h7; // source / 8
	localparam logic [1:0] ART_RESP_OKAY   = 2'h0;
	localparam logic [1:0] ART_RESP_SLVERR = 2'h2;

endpackage : art_pkg

// >>> rtl/art_sync.sv
// Two-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
`default_nettype none
module art_sync (
	// Clock and reset
	input  wire logic clk,
	input  wire logic srst,
	// Asynchronous level in, synchronised level out
	input  wire logic async_in,
	output var  logic sync_out
);
	logic meta_q;

	// First stage feeds the second stage only
	always_ff @(posedge clk) begin
		if (srst) begin
			meta_q   <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule : art_sync
`default_nettype wire

// >>> rtl/art_byte_cnt.sv
// One eight-bit counter byte with software load and auto-reload
`timescale 1ns/1ps
`default_nettype none
module art_byte_cnt
	import art_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       srst,
	// Software load
	input  wire logic       wr,
	input  wire logic [7:0] wdata,
	// Counting
	input  wire logic       inc,
	input  wire logic       rld,
	input  wire logic [7:0] rld_val,
	output var  logic [7:0] cnt_q
);
	// Software write beats the tick so a written value is never lost
	always_ff @(posedge clk) begin
		if (srst) begin
			cnt_q <= ART_RST_BYTE;
		end else if (wr) begin
			cnt_q <= wdata;
		end else if (inc) begin
			cnt_q <= rld ? rld_val : 8'(cnt_q + ART_BYTE_ONE);
		end
	end
endmodule : art_byte_cnt
`default_nettype wire

// >>> rtl/art_top.sv
// Auto-reload timer two with AXI4-Lite register access
`timescale 1ns/1ps
`default_nettype none
module art_top
	import art_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       srst,
	// External clock pins
	input  wire logic       ext_clk_in,
	input  wire logic       rtc_clk_in,
	// AXI4-Lite write address
	input  wire logic [7:0] s_awaddr,
	input  wire logic       s_awvalid,
	output var  logic       s_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] s_wdata,
	input  wire logic [3:0] s_wstrb,
	input  wire logic       s_wvalid,
	output var  logic       s_wready,
	// AXI4-Lite write response
	output var  logic [1:0] s_bresp,
	output var  logic       s_bvalid,
	input  wire logic       s_bready,
	// AXI4-Lite read address
	input  wire logic [7:0] s_araddr,
	input  wire logic       s_arvalid,
	output var  logic       s_arready,
	// AXI4-Lite read data
	output var  logic [31:0] s_rdata,
	output var  logic [1:0] s_rresp,
	output var  logic       s_rvalid,
	input  wire logic       s_rready,
	// Interrupt request
	output var  logic       irq
);
	// -----------------------------------------------------------------------
	// Declarations
	// -----------------------------------------------------------------------
	logic       aw_hold_q, w_hold_q;
	logic [7:0] aw_addr_q;
	logic [7:0] w_byte_q;
	logic       w_lane_q;
	logic       do_wr, wr_hit;
	logic       wr_ctl, wr_lo, wr_hi, wr_rll, wr_rlh, wr_ck, wr_ie;
	logic [7:0] rd_byte;
	logic       rd_hit;
	logic       hf_q, lf_q, lien_q, capen_q, split_q, run_q;
	logic       capsrc_q, xclk_q, hcksel_q, lcksel_q, timien_q;
	logic [7:0] rl_lo_q, rl_hi_q;
	logic [7:0] lo, hi;
	logic       ext_s, rtc_s, ext_p_q, rtc_p_q;
	logic [2:0] ext_div_q, rtc_div_q;
	logic [3:0] div12_q;
	logic       ext_tick, rtc_tick, div12_tick, shared_tick;
	logic       lo_tick, hi_tick, cap_tick;
	logic       lo_max, hi_max;
	logic       inc16, inc_lo, inc_hi, rld_lo, rld_hi;
	logic       set_lf, set_hf, capture;

	// -----------------------------------------------------------------------
	// AXI4-Lite write channel
	// -----------------------------------------------------------------------
	// Address and data are taken in either order; one write at a time
	always_ff @(posedge clk) begin
		if (srst) begin
			s_awready <= 1'b0;
			aw_hold_q <= 1'b0;
			aw_addr_q <= ART_RST_BYTE;
		end else if (s_awvalid && s_awready) begin
			s_awready <= 1'b0;
			aw_hold_q <= 1'b1;
			aw_addr_q <= {s_awaddr[7:2], 2'b00};
		end else if (do_wr) begin
			aw_hold_q <= 1'b0;
		end else if (!aw_hold_q && !s_bvalid) begin
			s_awready <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s_wready <= 1'b0;
			w_hold_q <= 1'b0;
			w_byte_q <= ART_RST_BYTE;
			w_lane_q <= 1'b0;
		end else if (s_wvalid && s_wready) begin
			s_wready <= 1'b0;
			w_hold_q <= 1'b1;
			w_byte_q <= s_wdata[7:0];
			w_lane_q <= s_wstrb[0]; // Registers live in byte lane 0
		end else if (do_wr) begin
			w_hold_q <= 1'b0;
		end else if (!w_hold_q && !s_bvalid) begin
			s_wready <= 1'b1;
		end
	end

	assign do_wr = aw_hold_q && w_hold_q && !s_bvalid;

	// Response follows once both halves are in
	always_ff @(posedge clk) begin
		if (srst) begin
			s_bvalid <= 1'b0;
			s_bresp  <= ART_RESP_OKAY;
		end else if (do_wr) begin
			s_bvalid <= 1'b1;
			s_bresp  <= wr_hit ? ART_RESP_OKAY : ART_RESP_SLVERR;
		end else if (s_bready) begin
			s_bvalid <= 1'b0;
		end
	end

	// Write decode; a cleared strobe still answers but stores nothing
	always_comb begin
		wr_hit = 1'b1;
		wr_ctl = 1'b0;
		wr_lo  = 1'b0;
		wr_hi  = 1'b0;
		wr_rll = 1'b0;
		wr_rlh = 1'b0;
		wr_ck  = 1'b0;
		wr_ie  = 1'b0;
		case (aw_addr_q)
			ART_OFF_CTRL:   wr_ctl = do_wr && w_lane_q;
			ART_OFF_CNT_LO: wr_lo  = do_wr && w_lane_q;
			ART_OFF_CNT_HI: wr_hi  = do_wr && w_lane_q;
			ART_OFF_RLD_LO: wr_rll = do_wr && w_lane_q;
			ART_OFF_RLD_HI: wr_rlh = do_wr && w_lane_q;
			ART_OFF_CKSEL:  wr_ck  = do_wr && w_lane_q;
			ART_OFF_IEN:    wr_ie  = do_wr && w_lane_q;
			default:        wr_hit = 1'b0;
		endcase
	end

	// -----------------------------------------------------------------------
	// AXI4-Lite read channel
	// -----------------------------------------------------------------------
	always_comb begin
		rd_hit  = 1'b1;
		rd_byte = ART_RST_BYTE;
		case ({s_araddr[7:2], 2'b00})
			ART_OFF_CTRL: rd_byte = {hf_q, lf_q, lien_q, capen_q,
				split_q, run_q, capsrc_q, xclk_q};
			ART_OFF_CNT_LO: rd_byte = lo;
			ART_OFF_CNT_HI: rd_byte = hi;
			ART_OFF_RLD_LO: rd_byte = rl_lo_q;
			ART_OFF_RLD_HI: rd_byte = rl_hi_q;
			ART_OFF_CKSEL: begin
				rd_byte[ART_B_HCKSEL] = hcksel_q;
				rd_byte[ART_B_LCKSEL] = lcksel_q;
			end
			ART_OFF_IEN: rd_byte[ART_B_TIMIEN] = timien_q;
			default:     rd_hit = 1'b0;
		endcase
	end

	// Data is captured on the address handshake, answered next cycle
	always_ff @(posedge clk) begin
		if (srst) begin
			s_arready <= 1'b0;
			s_rvalid  <= 1'b0;
			s_rdata   <= 32'h0000_0000;
			s_rresp   <= ART_RESP_OKAY;
		end else if (s_arvalid && s_arready) begin
			s_arready <= 1'b0;
			s_rvalid  <= 1'b1;
			s_rdata   <= {24'h00_0000, rd_byte};
			s_rresp   <= rd_hit ? ART_RESP_OKAY : ART_RESP_SLVERR;
		end else if (s_rvalid) begin
			if (s_rready) begin
				s_rvalid <= 1'b0;
			end
		end else begin
			s_arready <= 1'b1;
		end
	end

	// -----------------------------------------------------------------------
	// Control, select and enable bits
	// -----------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			{lien_q, capen_q, split_q, run_q, capsrc_q, xclk_q} <= 6'h00;
		end else if (wr_ctl) begin
			lien_q   <= w_byte_q[ART_B_LIEN];
			capen_q  <= w_byte_q[ART_B_CAPEN];
			split_q  <= w_byte_q[ART_B_SPLIT];
			run_q    <= w_byte_q[ART_B_RUN];
			capsrc_q <= w_byte_q[ART_B_CAPSRC];
			xclk_q   <= w_byte_q[ART_B_XCLK];
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			hcksel_q <= 1'b0;
			lcksel_q <= 1'b0;
			timien_q <= 1'b0;
		end else begin
			if (wr_ck) begin
				hcksel_q <= w_byte_q[ART_B_HCKSEL];
				lcksel_q <= w_byte_q[ART_B_LCKSEL];
			end
			if (wr_ie) begin
				timien_q <= w_byte_q[ART_B_TIMIEN];
			end
		end
	end

	// Overflow flags: hardware set wins over a software clear
	always_ff @(posedge clk) begin
		if (srst) begin
			hf_q <= 1'b0;
			lf_q <= 1'b0;
		end else begin
			hf_q <= (wr_ctl ? w_byte_q[ART_B_HFLAG] : hf_q) | set_hf;
			lf_q <= (wr_ctl ? w_byte_q[ART_B_LFLAG] : lf_q) | set_lf;
		end
	end

	// -----------------------------------------------------------------------
	// Tick sources
	// -----------------------------------------------------------------------
	// Pins are asynchronous, so both pass two flops first
	art_sync u_ext_sync (
		.clk      (clk),
		.srst     (srst),
		.async_in (ext_clk_in),
		.sync_out (ext_s)
	);

	art_sync u_rtc_sync (
		.clk      (clk),
		.srst     (srst),
		.async_in (rtc_clk_in),
		.sync_out (rtc_s)
	);

	// Rising-edge counters divide both pins by eight
	always_ff @(posedge clk) begin
		if (srst) begin
			ext_p_q   <= 1'b0;
			rtc_p_q   <= 1'b0;
			ext_div_q <= 3'h0;
			rtc_div_q <= 3'h0;
		end else begin
			ext_p_q <= ext_s;
			rtc_p_q <= rtc_s;
			if (ext_s && !ext_p_q) begin
				ext_div_q <= 3'(ext_div_q + 3'h1);
			end
			if (rtc_s && !rtc_p_q) begin
				rtc_div_q <= 3'(rtc_div_q + 3'h1);
			end
		end
	end

	assign ext_tick = ext_s && !ext_p_q && (ext_div_q == ART_DIV8_LAST);
	assign rtc_tick = rtc_s && !rtc_p_q && (rtc_div_q == ART_DIV8_LAST);

	// Free-running divide by twelve of the core clock
	always_ff @(posedge clk) begin
		if (srst) begin
			div12_q <= 4'h0;
		end else if (div12_q == ART_DIV12_LAST) begin
			div12_q <= 4'h0;
		end else begin
			div12_q <= 4'(div12_q + 4'h1);
		end
	end

	assign div12_tick  = (div12_q == ART_DIV12_LAST);
	assign shared_tick = xclk_q ? ext_tick : div12_tick;
	assign lo_tick     = lcksel_q ? 1'b1 : shared_tick;
	assign hi_tick     = hcksel_q ? 1'b1 : shared_tick;
	assign cap_tick    = capsrc_q ? ext_tick : rtc_tick;

	// -----------------------------------------------------------------------
	// Counter bytes
	// -----------------------------------------------------------------------
	assign lo_max = (lo == ART_BYTE_MAX);
	assign hi_max = (hi == ART_BYTE_MAX);
	assign inc16  = !split_q && run_q && lo_tick;
	// Split: low byte ignores run, high byte obeys it
	assign inc_lo = split_q ? lo_tick : inc16;
	assign inc_hi = split_q ? (run_q && hi_tick) : (inc16 && lo_max);
	// Low byte reloads alone in split mode, with the high byte otherwise
	assign rld_lo = split_q ? lo_max : (lo_max && hi_max);
	assign rld_hi = hi_max;
	assign set_lf = inc_lo && lo_max;
	assign capture = capen_q && cap_tick;
	assign set_hf = (inc_hi && hi_max) || capture;

	art_byte_cnt u_lo (
		.clk     (clk),
		.srst    (srst),
		.wr      (wr_lo),
		.wdata   (w_byte_q),
		.inc     (inc_lo),
		.rld     (rld_lo),
		.rld_val (rl_lo_q),
		.cnt_q   (lo)
	);

	art_byte_cnt u_hi (
		.clk     (clk),
		.srst    (srst),
		.wr      (wr_hi),
		.wdata   (w_byte_q),
		.inc     (inc_hi),
		.rld     (rld_hi),
		.rld_val (rl_hi_q),
		.cnt_q   (hi)
	);

	// Reload bytes; a capture overrides a software write that cycle
	always_ff @(posedge clk) begin
		if (srst) begin
			rl_lo_q <= ART_RST_BYTE;
			rl_hi_q <= ART_RST_BYTE;
		end else if (capture) begin
			rl_lo_q <= lo;
			rl_hi_q <= hi;
		end else begin
			if (wr_rll) begin
				rl_lo_q <= w_byte_q;
			end
			if (wr_rlh) begin
				rl_hi_q <= w_byte_q;
			end
		end
	end

	// Interrupt is a level held while an enabled flag stands
	always_ff @(posedge clk) begin
		if (srst) begin
			irq <= 1'b0;
		end else begin
			irq <= timien_q && (hf_q || (lien_q && lf_q));
		end
	end

	// -----------------------------------------------------------------------
	// Assertions
	// -----------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	AST_WRAP16_RELOAD: assert property (
		(!split_q && inc16 && lo_max && hi_max && !wr_lo && !wr_hi)
		|=> (lo == $past(rl_lo_q)) && (hi == $past(rl_hi_q)))
		else $error("sixteen-bit wrap did not reload");

	AST_WRAP16_FLAG: assert property (
		(!split_q && inc16 && lo_max && hi_max) |=> hf_q)
		else $error("sixteen-bit wrap did not set high flag");

	AST_IRQ_HIGH: assert property (
		(timien_q && hf_q) |=> irq)
		else $error("high flag with enable gave no interrupt");

	AST_IRQ_LOW: assert property (
		(timien_q && lien_q && lf_q && !wr_ie && !wr_ctl) |=> irq[*2])
		else $error("low flag with enables gave no interrupt");

	AST_STOPPED16: assert property (
		(!split_q && !run_q && !wr_lo && !wr_hi)
		|=> $stable(lo) && $stable(hi))
		else $error("stopped sixteen-bit counter moved");

	AST_SPLIT_LOW_RUNS: assert property (
		(split_q && !run_q && lo_tick && !lo_max && !wr_lo)
		|=> lo == 8'($past(lo) + ART_BYTE_ONE))
		else $error("low byte did not run in split mode");

	AST_SPLIT_HIGH_HELD: assert property (
		(split_q && !run_q && !wr_hi) |=> $stable(hi))
		else $error("high byte moved while stopped");

	AST_SPLIT_LOW_RELOAD: assert property (
		(split_q && lo_tick && lo_max && !wr_lo)
		|=> (lo == $past(rl_lo_q)) && lf_q)
		else $error("low byte split reload or flag missing");

	AST_SPLIT_HIGH_CORE: assert property (
		(split_q && run_q && hcksel_q && !hi_max && !wr_hi)
		|=> hi == 8'($past(hi) + ART_BYTE_ONE))
		else $error("high byte not on core clock");

	AST_FLAG_STICKY: assert property (
		(hf_q && !wr_ctl) |=> hf_q)
		else $error("high flag cleared by hardware");

	AST_CAPTURE: assert property (
		capture |=> (rl_lo_q == $past(lo)) && (rl_hi_q == $past(hi))
		&& hf_q)
		else $error("capture did not copy count");

	AST_EXT_DIV: assert property (
		ext_tick |=> (!ext_tick)[*3])
		else $error("external tick faster than divide by eight");

	COV_WRAP16: cover property (!split_q && inc16 && lo_max && hi_max);
	COV_SPLIT_HIGH: cover property (split_q && inc_hi && hi_max);
	// Flag lands one edge after capture, the interrupt one edge later
	COV_CAPTURE: cover property (capture ##2 irq);
	COV_IRQ_LOW: cover property (split_q && set_lf && lien_q && timien_q);

endmodule : art_top
`default_nettype wire

// >>> bench/auto_reload_timer_two_tb.sv
// Self-checking testbench of the auto-reload timer two
`timescale 1ns/1ps
`default_nettype none
module auto_reload_timer_two_tb;
	import art_pkg::*;

	// -----------------------------------------------------------------
	// Signals
	// -----------------------------------------------------------------
	logic        clk, srst, ext_clk_in, rtc_clk_in, irq;
	logic [7:0]  s_awaddr, s_araddr;
	logic        s_awvalid, s_awready, s_wvalid, s_wready;
	logic        s_bvalid, s_bready, s_arvalid, s_arready;
	logic        s_rvalid, s_rready;
	logic [31:0] s_wdata, s_rdata, rd_q;
	logic [3:0]  s_wstrb;
	logic [1:0]  s_bresp, s_rresp;
	logic [15:0] rl, v;
	logic [7:0]  rh;
	int          n_fail, tests_run;
	integer      seed;
	logic [7:0]  offs [7] = '{ART_OFF_CTRL, ART_OFF_CNT_LO, ART_OFF_CNT_HI,
		ART_OFF_RLD_LO, ART_OFF_RLD_HI, ART_OFF_CKSEL, ART_OFF_IEN};
	// Control word pieces
	localparam logic [31:0] FH = 32'h1 << ART_B_HFLAG;
	localparam logic [31:0] FL = 32'h1 << ART_B_LFLAG;
	localparam logic [31:0] LIE = 32'h1 << ART_B_LIEN;
	localparam logic [31:0] CAP = 32'h1 << ART_B_CAPEN;
	localparam logic [31:0] SPL = 32'h1 << ART_B_SPLIT;
	localparam logic [31:0] RUN = 32'h1 << ART_B_RUN;
	localparam logic [31:0] XCK = 32'h1 << ART_B_XCLK;
	localparam logic [31:0] CSR = 32'h1 << ART_B_CAPSRC;

	art_top u_dut (.clk(clk), .srst(srst), .ext_clk_in(ext_clk_in),
		.rtc_clk_in(rtc_clk_in), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
		.s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
		.s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
		.s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr),
		.s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
		.s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
		.irq(irq));

	// Core clock, 100 ns period
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// -----------------------------------------------------------------
	// Checking and closing
	// -----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Window check where bus latency blurs the tick count
	task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo,
			input logic [31:0] hi);
		tests_run++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
		end
	endtask : chk_rng

	task automatic report_and_stop;
		if (n_fail == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : report_and_stop

	task automatic give_up;
		n_fail++;
		$display("[ERR] t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
		report_and_stop();
	endtask : give_up

	// Expected count after n ticks, reloading past max
	function automatic logic [15:0] exp_cnt(input logic [15:0] s,
			input logic [15:0] r, input logic [15:0] mx, input int n);
		logic [15:0] x;
		x = s;
		for (int i = 0; i < n; i++)
			x = (x == mx) ? r : x + 16'h1;
		return x;
	endfunction : exp_cnt

	// -----------------------------------------------------------------
	// Bus master: holds each channel until its own handshake edge
	// -----------------------------------------------------------------
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
			input logic [3:0] st, input logic [1:0] er);
		int n;
		logic aw, w, done;
		aw = 1'b1;
		w = 1'b1;
		done = 1'b0;
		n = 0;
		s_awaddr <= a;
		s_awvalid <= 1'b1;
		s_wdata <= d;
		s_wstrb <= st;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		while (!done && n < 64) begin
			@(posedge clk);
			n++;
			if (!aw && !w && s_bvalid === 1'b1) done = 1'b1;
			if (aw && s_awready === 1'b1) begin
				aw = 1'b0;
				s_awvalid <= 1'b0;
			end
			if (w && s_wready === 1'b1) begin
				w = 1'b0;
				s_wvalid <= 1'b0;
			end
		end
		if (!done) give_up();
		chk({30'h0, s_bresp}, {30'h0, er});
		s_bready <= 1'b0;
		@(posedge clk);
	endtask : axi_write

	task automatic axi_read(input logic [7:0] a, input logic [1:0] er);
		int n;
		logic ar, done;
		ar = 1'b1;
		done = 1'b0;
		n = 0;
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		while (!done && n < 64) begin
			@(posedge clk);
			n++;
			if (!ar && s_rvalid === 1'b1) begin
				done = 1'b1;
				rd_q = s_rdata;
				chk({30'h0, s_rresp}, {30'h0, er});
			end
			if (ar && s_arready === 1'b1) begin
				ar = 1'b0;
				s_arvalid <= 1'b0;
			end
		end
		if (!done) give_up();
		s_rready <= 1'b0;
		@(posedge clk);
	endtask : axi_read

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		axi_write(a, d, 4'h1, ART_RESP_OKAY);
	endtask : wr

	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		axi_read(a, ART_RESP_OKAY);
		chk(rd_q, exp);
	endtask : rc

	// Pin pulses: 0 external source, 1 capture reference; idle low
	task automatic pulse(input logic sel, input int k);
		repeat (k) begin
			if (sel) rtc_clk_in <= 1'b1;
			else ext_clk_in <= 1'b1;
			repeat (2) @(posedge clk);
			if (sel) rtc_clk_in <= 1'b0;
			else ext_clk_in <= 1'b0;
			repeat (2) @(posedge clk);
		end
		repeat (6) @(posedge clk);
	endtask : pulse

	// -----------------------------------------------------------------
	// Main sequence; external bursts stay multiples of eight
	// -----------------------------------------------------------------
	initial begin
		seed = 32'hce871cab;
		{n_fail, tests_run} = '0;
		{srst, ext_clk_in, rtc_clk_in, s_awvalid, s_wvalid} = 5'h10;
		{s_bready, s_arvalid, s_rready} = 3'h0;
		{s_awaddr, s_araddr, s_wstrb, s_wdata} = '0;
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		repeat (2) @(posedge clk);
		for (int i = 0; i < 7; i++) rc(offs[i], 32'h0);
		axi_read(8'h1c, ART_RESP_SLVERR);
		chk(rd_q, 32'h0);
		axi_write(8'h1c, 32'hff, 4'hf, ART_RESP_SLVERR);
		axi_write(ART_OFF_RLD_LO, 32'h5a, 4'h0, ART_RESP_OKAY);
		rc(ART_OFF_RLD_LO, 32'h0);
		// Sixteen-bit wrap on the external source
		rl = 16'($random(seed));
		rl[7] = 1'b0;
		wr(ART_OFF_RLD_LO, {24'h0, rl[7:0]});
		wr(ART_OFF_RLD_HI, {24'h0, rl[15:8]});
		wr(ART_OFF_CNT_LO, 32'hfe);
		wr(ART_OFF_CNT_HI, 32'hff);
		wr(ART_OFF_IEN, 32'h1 << ART_B_TIMIEN);
		wr(ART_OFF_CTRL, RUN | XCK);
		pulse(1'b0, 24);
		v = exp_cnt(16'hfffe, rl, 16'hffff, 3);
		rc(ART_OFF_CNT_LO, {24'h0, v[7:0]});
		rc(ART_OFF_CNT_HI, {24'h0, v[15:8]});
		axi_read(ART_OFF_CTRL, ART_RESP_OKAY);
		chk(rd_q & 32'h8f, FH | RUN | XCK);
		chk({31'h0, irq}, 32'h1);
		wr(ART_OFF_CTRL, RUN | XCK);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		// Low byte wrap alone in sixteen-bit mode
		wr(ART_OFF_CNT_LO, 32'hff);
		wr(ART_OFF_CNT_HI, 32'h00);
		wr(ART_OFF_CTRL, LIE | RUN | XCK);
		pulse(1'b0, 8);
		rc(ART_OFF_CNT_HI, 32'h1);
		rc(ART_OFF_CTRL, FL | LIE | RUN | XCK);
		chk({31'h0, irq}, 32'h1);
		wr(ART_OFF_CTRL, FL | RUN | XCK);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		rc(ART_OFF_CTRL, FL | RUN | XCK);
		// Split mode: low runs, high waits for run control
		rl = 16'($random(seed)) & 16'h7f;
		rh = 8'($random(seed));
		wr(ART_OFF_CTRL, SPL | XCK);
		wr(ART_OFF_RLD_LO, {16'h0, rl});
		wr(ART_OFF_RLD_HI, {24'h0, rh});
		wr(ART_OFF_CNT_LO, 32'hff);
		wr(ART_OFF_CNT_HI, 32'hff);
		pulse(1'b0, 16);
		rc(ART_OFF_CNT_LO, {16'h0, rl + 16'h1});
		rc(ART_OFF_CNT_HI, 32'hff);
		rc(ART_OFF_CTRL, FL | SPL | XCK);
		wr(ART_OFF_CTRL, SPL | RUN | XCK);
		pulse(1'b0, 8);
		rc(ART_OFF_CNT_HI, {24'h0, rh});
		rc(ART_OFF_CNT_LO, {16'h0, rl + 16'h2});
		rc(ART_OFF_CTRL, FH | SPL | RUN | XCK);
		chk({31'h0, irq}, 32'h1);
		wr(ART_OFF_CTRL, FL | SPL | RUN | XCK);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		wr(ART_OFF_CTRL, FL | LIE | SPL | RUN | XCK);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h1);
		// Per-byte selects: high on core clock, low idle on external
		wr(ART_OFF_CKSEL, 32'h1 << ART_B_HCKSEL);
		wr(ART_OFF_CNT_LO, 32'h10);
		wr(ART_OFF_CNT_HI, 32'h0);
		repeat (20) @(posedge clk);
		rc(ART_OFF_CNT_LO, 32'h10);
		axi_read(ART_OFF_CNT_HI, ART_RESP_OKAY);
		chk_rng(rd_q, 32'd20, 32'd40);
		// Divide-by-12 on the low byte
		wr(ART_OFF_CKSEL, 32'h0);
		wr(ART_OFF_CTRL, SPL);
		wr(ART_OFF_CNT_LO, 32'h0);
		repeat (120) @(posedge clk);
		axi_read(ART_OFF_CNT_LO, ART_RESP_OKAY);
		chk_rng(rd_q, 32'd9, 32'd12);
		// Core clock in sixteen-bit mode
		wr(ART_OFF_CKSEL, 32'h1 << ART_B_LCKSEL);
		wr(ART_OFF_CTRL, RUN);
		wr(ART_OFF_CNT_HI, 32'h0);
		wr(ART_OFF_CNT_LO, 32'h0);
		repeat (50) @(posedge clk);
		axi_read(ART_OFF_CNT_LO, ART_RESP_OKAY);
		chk_rng(rd_q, 32'd50, 32'd60);
		// Capture on eight reference edges with the count stopped
		wr(ART_OFF_CTRL, 32'h0);
		wr(ART_OFF_CNT_LO, 32'h34);
		wr(ART_OFF_CNT_HI, 32'h12);
		wr(ART_OFF_RLD_LO, 32'h0);
		wr(ART_OFF_RLD_HI, 32'h0);
		wr(ART_OFF_CTRL, CAP);
		pulse(1'b1, 8);
		rc(ART_OFF_RLD_LO, 32'h34);
		rc(ART_OFF_RLD_HI, 32'h12);
		rc(ART_OFF_CTRL, FH | CAP);
		// Capture on eight external edges instead of the reference
		wr(ART_OFF_CNT_LO, 32'h56);
		wr(ART_OFF_CTRL, CAP | CSR);
		pulse(1'b0, 8);
		rc(ART_OFF_RLD_LO, 32'h56);
		rc(ART_OFF_RLD_HI, 32'h12);
		rc(ART_OFF_CTRL, FH | CAP | CSR);
		report_and_stop();
	end

endmodule : auto_reload_timer_two_tb
`default_nettype wire
